// File: verilog/power_task_event_pkg.sv
// Purpose: shared constants and types for the power task/event register bank
// Assumes: apb with 32-bit data, byte addresses equal printed offsets
// Notes: one aligned word per register
package power_task_event_pkg;
  localparam int unsigned ADDR_W = 12;
  localparam logic [11:0] CONSTANT_LATENCY_TRIGGER_OFS = 12'h078;
  localparam logic [11:0] LOW_POWER_TRIGGER_OFS = 12'h07C;
  localparam logic [11:0] POWER_FAIL_WARNING_FLAG_OFS = 12'h108;
  localparam logic [11:0] SLEEP_ENTERED_FLAG_OFS = 12'h114;
  localparam logic [11:0] SLEEP_EXITED_FLAG_OFS = 12'h118;
  localparam logic [11:0] INTERRUPT_ENABLE_SET_OFS = 12'h304;
  localparam logic [11:0] INTERRUPT_ENABLE_CLEAR_OFS = 12'h308;
  localparam logic [11:0] LATENCY_STATUS_OFS = 12'h000;
  localparam int unsigned NUM_EVENTS = 3;
  localparam int unsigned BIT_POWER_FAIL_WARNING = 0;
  localparam int unsigned BIT_SLEEP_ENTERED = 1;
  localparam int unsigned BIT_SLEEP_EXITED = 2;
  localparam logic [31:0] REG_RESET = 32'h0000_0000;
  localparam logic [2:0] ENABLE_RESET = 3'h0;
  localparam logic [2:0] FLAG_RESET = 3'h0;
  localparam logic LATENCY_MODE_RESET = 1'b0;
  // access phase state of the slave
  typedef enum logic [0:0] {
    BUS_IDLE = 1'b0,
    BUS_ACCESS = 1'b1
  } bus_state_t;
endpackage : power_task_event_pkg

// File: verilog/event_flag_if.sv
// Purpose: carries event sources and flag writes between bank and flag module
// Assumes: single clock domain
// Notes: pulses are one cycle wide
`timescale 1ns/10ps
interface event_flag_if;
  logic [2:0] source;
  logic [2:0] wr_strobe;
  logic [2:0] wr_value;
  logic [2:0] flags;
  modport bank (output source, output wr_strobe, output wr_value, input flags);
  modport store (input source, input wr_strobe, input wr_value, output flags);
endinterface : event_flag_if

// File: verilog/event_flags.sv
// Purpose: holds the sticky event flags
// Assumes: sources are single-cycle pulses on clock_in
// Notes: an event in the cycle of a software write wins
`timescale 1ns/10ps
module event_flags
(
  input wire logic clock_in,
  input wire logic rst_in,
  event_flag_if.store ev
);
  typedef struct packed {
    logic [2:0] flags;
  } flag_state_t;
  flag_state_t state_q;
  flag_state_t state_d;

  // software write then hardware set, set wins
  always_comb
  begin
    state_d = state_q;
    for (int i = 0; i < 3; i++)
    begin
      if (ev.wr_strobe[i])
      begin
        state_d.flags[i] = ev.wr_value[i];
      end
      if (ev.source[i])
      begin
        state_d.flags[i] = 1'b1;
      end
    end
  end

  // state register
  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      state_q <= '{flags: power_task_event_pkg::FLAG_RESET};
    end
    else
    begin
      state_q <= state_d;
    end
  end

  assign ev.flags = state_q.flags;
endmodule : event_flags

// File: verilog/edge_sync.sv
// Purpose: two-stage synchroniser with rising and falling edge pulses
// Assumes: input from outside the clock domain
// Notes: edges are taken from the second and third stage only
`timescale 1ns/10ps
module edge_sync
(
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic level_in,
  output logic rise_out,
  output logic fall_out
);
  typedef struct packed {
    logic meta;
    logic sync;
    logic last;
  } sync_state_t;
  sync_state_t state_q;
  sync_state_t state_d;

  // shift chain
  always_comb
  begin
    state_d.meta = level_in;
    state_d.sync = state_q.meta;
    state_d.last = state_q.sync;
  end

  // state register
  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      state_q <= '0;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  assign rise_out = state_q.sync & ~state_q.last;
  assign fall_out = ~state_q.sync & state_q.last;
endmodule : edge_sync

// File: verilog/power_task_event_regs.sv
// Purpose: task, event and interrupt enable registers of the power unit
// Assumes: apb slave, comparator warning and cpu sleep level come from other domains
// Notes: pready is high in every access phase, no wait states
`timescale 1ns/10ps
// Function
// (RULE1) write 1 starts constant latency mode
// (RULE2) write 1 starts low power mode
// (RULE3) sleep entered flag set on sleep entry
// (RULE4) sleep exited flag set on sleep exit
// (RULE5) set bit0 enables power fail interrupt
// (RULE6) set bit1 enables sleep entered interrupt
// (RULE7) set bit2 enables sleep exited; reset clears
// (RULE8) clear register disables, reads enable state
// (RULE9) irq when enabled flag set; zeros ignored
module power_task_event_regs
(
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic power_fail_warning_in,
  input wire logic cpu_sleeping_in,
  output logic constant_latency_out,
  output logic constant_latency_start_out,
  output logic low_power_start_out,
  output logic irq_out
);
  typedef struct packed {
    logic [2:0] enable;
    logic const_lat;
    logic cl_start;
    logic lp_start;
    logic irq;
  } bank_state_t;
  bank_state_t state_q;
  bank_state_t state_d;

  event_flag_if ev ();
  logic pof_rise;
  logic sleep_rise;
  logic sleep_fall;
  logic access;
  logic wr;
  logic [11:0] addr;
  logic hit;
  logic [31:0] rvalue;

  // synchronised event sources
  edge_sync pof_sync
  (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .level_in(power_fail_warning_in),
    .rise_out(pof_rise),
    .fall_out()
  );
  edge_sync sleep_sync
  (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .level_in(cpu_sleeping_in),
    .rise_out(sleep_rise),
    .fall_out(sleep_fall)
  );

  event_flags flags_inst
  (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .ev(ev)
  );

  // bus decode; refused addresses never write, so upper bits cannot alias
  assign access = psel & penable;
  assign wr = access & pwrite & hit;
  assign addr = paddr[11:0];
  assign hit = (paddr[31:12] == 20'h00000) && (paddr[1:0] == 2'h0) &&
    ((addr == power_task_event_pkg::CONSTANT_LATENCY_TRIGGER_OFS) ||
     (addr == power_task_event_pkg::LOW_POWER_TRIGGER_OFS) ||
     (addr == power_task_event_pkg::POWER_FAIL_WARNING_FLAG_OFS) ||
     (addr == power_task_event_pkg::SLEEP_ENTERED_FLAG_OFS) ||
     (addr == power_task_event_pkg::SLEEP_EXITED_FLAG_OFS) ||
     (addr == power_task_event_pkg::INTERRUPT_ENABLE_SET_OFS) ||
     (addr == power_task_event_pkg::INTERRUPT_ENABLE_CLEAR_OFS) ||
     (addr == power_task_event_pkg::LATENCY_STATUS_OFS));

  // event sources into the flag store
  assign ev.source = {sleep_fall, sleep_rise, pof_rise}; // RULE3 RULE4 RULE5

  // software writes to the flag registers, low byte lane carries bit 0
  always_comb
  begin
    ev.wr_strobe = 3'h0;
    ev.wr_value = {3{pwdata[0]}};
    if (wr && pstrb[0])
    begin
      ev.wr_strobe[0] = (addr == power_task_event_pkg::POWER_FAIL_WARNING_FLAG_OFS); // RULE5
      ev.wr_strobe[1] = (addr == power_task_event_pkg::SLEEP_ENTERED_FLAG_OFS); // RULE3
      ev.wr_strobe[2] = (addr == power_task_event_pkg::SLEEP_EXITED_FLAG_OFS); // RULE4
    end
  end

  // read mux, write-only triggers read zero
  always_comb
  begin
    rvalue = power_task_event_pkg::REG_RESET;
    case (addr)
      power_task_event_pkg::POWER_FAIL_WARNING_FLAG_OFS:
        rvalue[0] = ev.flags[power_task_event_pkg::BIT_POWER_FAIL_WARNING];
      power_task_event_pkg::SLEEP_ENTERED_FLAG_OFS:
        rvalue[0] = ev.flags[power_task_event_pkg::BIT_SLEEP_ENTERED]; // RULE3
      power_task_event_pkg::SLEEP_EXITED_FLAG_OFS:
        rvalue[0] = ev.flags[power_task_event_pkg::BIT_SLEEP_EXITED]; // RULE4
      power_task_event_pkg::INTERRUPT_ENABLE_SET_OFS:
        rvalue[2:0] = state_q.enable; // RULE6 RULE7
      power_task_event_pkg::INTERRUPT_ENABLE_CLEAR_OFS:
        rvalue[2:0] = state_q.enable; // RULE8
      power_task_event_pkg::LATENCY_STATUS_OFS:
        rvalue[0] = state_q.const_lat;
      default:
        rvalue = power_task_event_pkg::REG_RESET; // RULE1
    endcase
  end

  // register bank next state
  always_comb
  begin
    state_d = state_q;
    state_d.cl_start = 1'b0;
    state_d.lp_start = 1'b0;
    if (wr && pstrb[0])
    begin
      if (addr == power_task_event_pkg::CONSTANT_LATENCY_TRIGGER_OFS && pwdata[0])
      begin
        state_d.const_lat = 1'b1; // RULE1
        state_d.cl_start = 1'b1; // RULE1
      end
      if (addr == power_task_event_pkg::LOW_POWER_TRIGGER_OFS && pwdata[0])
      begin
        state_d.const_lat = 1'b0; // RULE2
        state_d.lp_start = 1'b1; // RULE2
      end
      if (addr == power_task_event_pkg::INTERRUPT_ENABLE_SET_OFS)
      begin
        state_d.enable = state_q.enable | pwdata[2:0]; // RULE5 RULE6 RULE7 RULE9
      end
      if (addr == power_task_event_pkg::INTERRUPT_ENABLE_CLEAR_OFS)
      begin
        state_d.enable = state_q.enable & ~pwdata[2:0]; // RULE8 RULE9
      end
    end
    state_d.irq = |(ev.flags & state_q.enable); // RULE9
  end

  // state register, all enables cleared at reset
  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      state_q <= '{enable: power_task_event_pkg::ENABLE_RESET, // RULE7
        const_lat: power_task_event_pkg::LATENCY_MODE_RESET,
        cl_start: 1'b0, lp_start: 1'b0, irq: 1'b0};
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // outputs; read data shown combinationally during the access phase
  assign prdata = hit ? rvalue : power_task_event_pkg::REG_RESET;
  assign pready = 1'b1;
  assign pslverr = access & ~hit;
  assign constant_latency_out = state_q.const_lat;
  assign constant_latency_start_out = state_q.cl_start;
  assign low_power_start_out = state_q.lp_start;
  assign irq_out = state_q.irq;
endmodule : power_task_event_regs

// File: verif/power_task_event_chk.sv
// Purpose: port checks on the power task/event bank
// Assumes: zero wait states, synchronous active-high reset
// Notes: enable shadow is rebuilt from bus writes
`timescale 1ns/10ps
module power_task_event_chk
(
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic power_fail_warning_in,
  input wire logic cpu_sleeping_in,
  input wire logic constant_latency_out,
  input wire logic constant_latency_start_out,
  input wire logic low_power_start_out,
  input wire logic irq_out
);
  logic [2:0] en_q;
  logic wr;
  logic rd;
  default clocking @(posedge clock_in); endclocking
  default disable iff (rst_in);
  // completed writes and reads
  assign wr = psel && penable && pwrite && pstrb[0];
  assign rd = psel && penable && !pwrite;
  // shadow of the interrupt enables
  always_ff @(posedge clock_in)
    if (rst_in)
      en_q <= 3'h0;
    else if (wr && paddr == 32'h304)
      en_q <= en_q | pwdata[2:0];
    else if (wr && paddr == 32'h308)
      en_q <= en_q & ~pwdata[2:0];
  cl_start_a: assert property (wr && paddr == 32'h78 && pwdata[0]
    |=> constant_latency_start_out && constant_latency_out) else $error("no cl start");
  lp_start_a: assert property (wr && paddr == 32'h7C && pwdata[0]
    |=> low_power_start_out && !constant_latency_out) else $error("no lp start");
  trig_read_a: assert property (rd && paddr[31:3] == 29'hF
    |-> prdata == 32'h0) else $error("trigger read not zero");
  en_read_a: assert property (rd && (paddr == 32'h304 || paddr == 32'h308)
    |-> prdata == {29'h0, en_q}) else $error("enable read wrong");
  irq_off_a: assert property (en_q == 3'h0 |=> !irq_out) else $error("irq while masked");
  mode_hold_a: assert property (!$past(wr) |-> $stable(constant_latency_out))
    else $error("mode moved");
  status_rd_a: assert property (rd && paddr == 32'h0
    |-> prdata == {31'h0, constant_latency_out}) else $error("status wrong");
  no_wait_a: assert property (psel && penable |-> pready) else $error("wait state");
  unmapped_a: assert property (rd && paddr == 32'h200 |-> pslverr && prdata == 32'h0)
    else $error("unmapped read");
  cover property (constant_latency_start_out);
  cover property (irq_out);
  cover property (pslverr);
endmodule : power_task_event_chk

bind power_task_event_regs power_task_event_chk u_chk (.*);

// File: verif/tb_top.sv
// Purpose: directed tests of the power task/event bank
// Assumes: apb slave with no wait states, 125 MHz clock
// Notes: flags follow synchronised sleep and warning inputs
`timescale 1ns/10ps
module tb_top;
  logic clock_in = 1'b0, rst_in = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd_v;
  logic [3:0] pstrb = 4'hF;
  logic pready, pslverr, err_v, constant_latency_out, constant_latency_start_out;
  logic power_fail_warning_in = 1'b0, cpu_sleeping_in = 1'b0, low_power_start_out, irq_out;
  int fail_count = 0, compares = 0, cycles = 0;
  power_task_event_regs u_dut (.*);
  // clock and run limit
  always #4 clock_in = ~clock_in;
  always @(posedge clock_in)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      fail_count++;
      tally_and_finish();
    end
  end
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] want);
    compares++;
    if (seen !== want)
    begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, want, seen);
    end
  endtask : chk
  // one apb transfer, result kept in rd_v and err_v
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clock_in);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock_in);
    penable <= 1'b1;
    @(posedge clock_in);
    while (pready !== 1'b1)
      @(posedge clock_in);
    rd_v = prdata;
    err_v = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : bus
  task automatic t_reset();
    logic [31:0] regs [7] = '{32'h0, 32'h78, 32'h7C, 32'h108, 32'h114, 32'h118, 32'h304};
    foreach (regs[i])
    begin
      bus(1'b0, regs[i], 32'h0);
      chk("reset value", rd_v, 32'h0);
    end
    $display("reset test done");
  endtask : t_reset
  task automatic t_trigger();
    bus(1'b1, 32'h78, 32'h1);
    @(negedge clock_in);
    chk("cl start", constant_latency_start_out, 1);
    chk("cl mode", constant_latency_out, 1);
    @(negedge clock_in);
    chk("cl start end", constant_latency_start_out, 0);
    bus(1'b1, 32'h7C, 32'h0);
    @(negedge clock_in);
    chk("lp zero ignored", constant_latency_out, 1);
    chk("lp zero no start", low_power_start_out, 0);
    bus(1'b1, 32'h7C, 32'h1);
    @(negedge clock_in);
    chk("lp start", low_power_start_out, 1);
    chk("lp mode", constant_latency_out, 0);
    @(negedge clock_in);
    chk("lp start end", low_power_start_out, 0);
    $display("trigger test done");
  endtask : t_trigger
  task automatic t_enables();
    logic [31:0] ops [6] = '{32'h304, 32'h304, 32'h304, 32'h308, 32'h308, 32'h308};
    logic [2:0] dat [6] = '{3'h5, 3'h0, 3'h2, 3'h1, 3'h0, 3'h6};
    logic [2:0] want [6] = '{3'h5, 3'h5, 3'h7, 3'h6, 3'h6, 3'h0};
    for (int i = 0; i < 6; i++)
    begin
      bus(1'b1, ops[i], {29'h0, dat[i]});
      bus(1'b0, 32'h304, 32'h0);
      chk("enable set", rd_v, {29'h0, want[i]});
      bus(1'b0, 32'h308, 32'h0);
      chk("enable clear", rd_v, {29'h0, want[i]});
    end
    bus(1'b1, 32'h200, 32'hFFFFFFFF);
    chk("unmapped error", err_v, 1);
    bus(1'b0, 32'h200, 32'h0);
    chk("unmapped read error", err_v, 1);
    chk("unmapped read data", rd_v, 0);
    bus(1'b1, 32'h1304, 32'h7);
    chk("alias error", err_v, 1);
    bus(1'b0, 32'h304, 32'h0);
    chk("alias ignored", rd_v, 0);
    $display("enable test done");
  endtask : t_enables
  task automatic t_events();
    bus(1'b1, 32'h304, 32'h2);
    cpu_sleeping_in <= 1'b1;
    repeat (8) @(posedge clock_in);
    bus(1'b0, 32'h114, 32'h0);
    chk("entered", rd_v, 1);
    chk("irq entered", irq_out, 1);
    bus(1'b1, 32'h114, 32'h0);
    bus(1'b0, 32'h114, 32'h0);
    chk("entered cleared", rd_v, 0);
    cpu_sleeping_in <= 1'b0;
    chk("irq cleared", irq_out, 0);
    repeat (8) @(posedge clock_in);
    bus(1'b0, 32'h118, 32'h0);
    chk("exited", rd_v, 1);
    chk("irq masked", irq_out, 0);
    bus(1'b1, 32'h304, 32'h4);
    repeat (2) @(posedge clock_in);
    chk("irq exited", irq_out, 1);
    power_fail_warning_in <= 1'b1;
    repeat (8) @(posedge clock_in);
    bus(1'b0, 32'h108, 32'h0);
    chk("warning", rd_v, 1);
    $display("event test done");
  endtask : t_events
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish
  // main sequence
  initial
  begin
    repeat (20) @(posedge clock_in);
    rst_in <= 1'b0;
    t_reset();
    t_trigger();
    t_enables();
    t_events();
    tally_and_finish();
  end
endmodule : tb_top
